// ---- verilog/irm_pkg.sv ----
package irm_pkg;

  // ---------------------------------------------------------------------------
  // Context count and bus widths.
  // ---------------------------------------------------------------------------
  localparam int CTX_COUNT = 4;  // Number of receive contexts.
  localparam int ADDR_W = 16;  // APB address width.
  localparam int DATA_W = 32;  // APB data width.

  // ---------------------------------------------------------------------------
  // Register map; each context owns one 32-byte slot.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] MATCH_BASE = 16'h410c;  // Context match register, context 0.
  localparam logic [15:0] CTRL_BASE = 16'h4110;  // Context control register, context 0.
  localparam logic [15:0] CTX_STRIDE = 16'h0020;  // Byte distance between contexts.
  localparam int SLOT_LO = 5;  // Lowest address bit that selects the context.
  localparam int SLOT_HI = 6;  // Highest address bit that selects the context.
  localparam int REGION_LO = 7;  // Lowest address bit of the region tag.

  // ---------------------------------------------------------------------------
  // Match register fields.
  // ---------------------------------------------------------------------------
  localparam int TAG11_BIT = 31;  // Accept tag binary 11.
  localparam int TAG10_BIT = 30;  // Accept tag binary 10.
  localparam int TAG01_BIT = 29;  // Accept tag binary 01.
  localparam int TAG00_BIT = 28;  // Accept tag binary 00.
  localparam int CYC_HI = 26;  // Start-cycle compare, top bit.
  localparam int CYC_LO = 12;  // Start-cycle compare, bottom bit.
  localparam int SYNC_HI = 11;  // Sync compare, top bit.
  localparam int SYNC_LO = 8;  // Sync compare, bottom bit.
  localparam int SYNC_GATE_BIT = 6;  // Tag-one sync gate.
  localparam int CHAN_HI = 5;  // Channel select, top bit.
  localparam logic [31:0] MATCH_WMASK = 32'hf7ffff7f;  // Bits 27 and 7 stay zero.
  localparam logic [31:0] MATCH_RESET = 32'h00000000;  // Match register after reset.

  // ---------------------------------------------------------------------------
  // Control register fields.
  // ---------------------------------------------------------------------------
  localparam int SOCE_BIT = 29;  // Start-on-cycle enable.
  localparam int RUN_BIT = 15;  // Context run.
  localparam int STARTED_BIT = 10;  // Read-only: context open for receives.
  localparam logic [31:0] CTRL_WMASK = 32'h20008000;  // Writable control bits.
  localparam logic [31:0] CTRL_RESET = 32'h00000000;  // Control register after reset.

  // ---------------------------------------------------------------------------
  // Packet field values.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] WAIT_ON_SYNC = 2'h3;  // Descriptor wait selector for sync wait.
  localparam logic [1:0] SYNC_TOP_OPEN = 2'h0;  // Sync top bits that pass the gate.

endpackage

// ---- verilog/irm_filter.sv ----
// Decides, for one context, whether the offered packet is accepted and
// whether its sync value satisfies a descriptor sync wait.
module irm_filter
(
  input wire logic [31:0] matchWord,  // Context match register.
  input wire logic started,  // Context open for receives.
  input wire logic pktValid,  // Packet offered this cycle.
  input wire logic [5:0] pktChannel,  // Packet channel.
  input wire logic [1:0] pktTag,  // Packet tag.
  input wire logic [3:0] pktSync,  // Packet sync.
  input wire logic [1:0] waitSelect,  // Active descriptor wait selector.
  output logic accept,  // Packet goes into this context.
  output logic syncHit  // Sync wait satisfied.
);
  import irm_pkg::*;

  logic chanHit;  // Channel equals the selected one.
  logic tagPass;  // Tag passes the enabled tag and gate checks.

  // ---------------------------------------------------------------------------
  // Combinational filter.
  // ---------------------------------------------------------------------------
  always_comb
  begin
    chanHit = pktChannel == matchWord[CHAN_HI:0];
    case (pktTag)
      2'h3: tagPass = matchWord[TAG11_BIT];
      2'h2: tagPass = matchWord[TAG10_BIT];
      2'h1:
      begin
        // The gate only narrows tag 01 traffic; when clear, the bit alone decides.
        tagPass = matchWord[TAG01_BIT] &&
          (!matchWord[SYNC_GATE_BIT] || pktSync[3:2] == SYNC_TOP_OPEN);
      end
      default: tagPass = matchWord[TAG00_BIT];
    endcase
    accept = pktValid && chanHit && tagPass && started;
    syncHit = pktValid && chanHit && started && waitSelect == WAIT_ON_SYNC &&
      pktSync == matchWord[SYNC_HI:SYNC_LO];
  end

endmodule

// ---- verilog/irm_match_filter.sv ----
// Our own choice: the APB register port.
module irm_match_filter
(
  input wire logic clk_sys,  // System clock, 10 MHz.
  input wire logic reset,  // Asynchronous reset, active high.
  input wire logic psel,  // APB select.
  input wire logic penable,  // APB enable.
  input wire logic pwrite,  // APB write.
  input wire logic [irm_pkg::ADDR_W-1:0] paddr,  // APB byte address.
  input wire logic [irm_pkg::DATA_W-1:0] pwdata,  // APB write data.
  output logic [irm_pkg::DATA_W-1:0] prdata,  // APB read data.
  output logic pready,  // APB ready.
  output logic pslverr,  // APB error for unmapped addresses.
  input wire logic pktValid,  // Packet header offered, one cycle.
  input wire logic [5:0] pktChannel,  // Packet channel number.
  input wire logic [1:0] pktTag,  // Packet tag field.
  input wire logic [3:0] pktSync,  // Packet sync field.
  input wire logic [6:0] timerSecondsCount,  // Cycle timer seconds.
  input wire logic [12:0] timerCycleIndex,  // Cycle timer cycle count.
  input wire logic [2*irm_pkg::CTX_COUNT-1:0] waitSelect,  // Wait selector, two bits a context.
  output logic [irm_pkg::CTX_COUNT-1:0] pktAccept,  // Packet accepted, per context.
  output logic [irm_pkg::CTX_COUNT-1:0] syncHit,  // Sync wait met, per context.
  output logic [irm_pkg::CTX_COUNT-1:0] ctxStarted  // Context open for receives.
);
  import irm_pkg::*;

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [CTX_COUNT-1:0][31:0] matchReg;  // Match registers.
    logic [CTX_COUNT-1:0] runReg;  // Run bits.
    logic [CTX_COUNT-1:0] soceReg;  // Start-on-cycle enable bits.
    logic [CTX_COUNT-1:0] startedReg;  // Context open for receives.
    logic [CTX_COUNT-1:0] acceptReg;  // Registered accept pulses.
    logic [CTX_COUNT-1:0] syncHitReg;  // Registered sync hit pulses.
    logic [31:0] prdataReg;  // Read data.
    logic preadyReg;  // Ready.
    logic pslverrReg;  // Error.
  } irm_state_t;

  irm_state_t s_reg;  // Current state.
  irm_state_t s_next;  // Next state.
  logic [CTX_COUNT-1:0] acceptVec;  // Filter accept decisions.
  logic [CTX_COUNT-1:0] hitVec;  // Filter sync hits.
  logic [CTX_COUNT-1:0] cycleHit;  // Timer equals compare field.
  logic [14:0] timerNow;  // Low seconds bits and cycle count.

  // ---------------------------------------------------------------------------
  // Address decoding.
  // ---------------------------------------------------------------------------
  // True when the address selects a context's match register.
  function automatic logic isMatchAddr(input logic [ADDR_W-1:0] a);
    isMatchAddr = a[ADDR_W-1:REGION_LO] == MATCH_BASE[ADDR_W-1:REGION_LO] &&
      a[SLOT_LO-1:0] == MATCH_BASE[SLOT_LO-1:0];
  endfunction

  // True when the address selects a context's control register.
  function automatic logic isCtrlAddr(input logic [ADDR_W-1:0] a);
    isCtrlAddr = a[ADDR_W-1:REGION_LO] == CTRL_BASE[ADDR_W-1:REGION_LO] &&
      a[SLOT_LO-1:0] == CTRL_BASE[SLOT_LO-1:0];
  endfunction

  // ---------------------------------------------------------------------------
  // Per-context filters.
  // ---------------------------------------------------------------------------
  assign timerNow = {timerSecondsCount[1:0], timerCycleIndex};

  genvar g;
  generate
    for (g = 0; g < CTX_COUNT; g++)
    begin : gCtx
      // The compare field holds two seconds bits over the cycle count.
      assign cycleHit[g] = s_reg.matchReg[g][CYC_HI:CYC_LO] == timerNow;

      irm_filter uFilter
      (
        .matchWord(s_reg.matchReg[g]),
        .started(s_reg.startedReg[g]),
        .pktValid(pktValid),
        .pktChannel(pktChannel),
        .pktTag(pktTag),
        .pktSync(pktSync),
        .waitSelect(waitSelect[2*g+1:2*g]),
        .accept(acceptVec[g]),
        .syncHit(hitVec[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------
  // The APB access phase lasts two cycles: the first loads read data and
  // raises pready, and writes land at the edge that samples pready.
  always_comb
  begin
    logic [1:0] slot;
    slot = paddr[SLOT_HI:SLOT_LO];
    s_next = s_reg;
    s_next.acceptReg = acceptVec;
    s_next.syncHitReg = hitVec;
    s_next.preadyReg = psel && penable && !s_reg.preadyReg;
    s_next.pslverrReg = 1'b0;
    if (psel && penable && !s_reg.preadyReg)
    begin
      // Load read data; reserved bits come back as zero.
      if (isMatchAddr(paddr))
      begin
        s_next.prdataReg = s_reg.matchReg[slot] & MATCH_WMASK;
      end
      else if (isCtrlAddr(paddr))
      begin
        s_next.prdataReg = 32'h00000000;
        s_next.prdataReg[SOCE_BIT] = s_reg.soceReg[slot];
        s_next.prdataReg[RUN_BIT] = s_reg.runReg[slot];
        s_next.prdataReg[STARTED_BIT] = s_reg.startedReg[slot];
      end
      else
      begin
        s_next.prdataReg = 32'h00000000;
        s_next.pslverrReg = 1'b1;
      end
    end
    if (psel && penable && s_reg.preadyReg && pwrite)
    begin
      // Commit the write; reserved positions are never stored.
      if (isMatchAddr(paddr))
      begin
        s_next.matchReg[slot] = pwdata & MATCH_WMASK;
      end
      else if (isCtrlAddr(paddr))
      begin
        s_next.runReg[slot] = pwdata[RUN_BIT];
        s_next.soceReg[slot] = pwdata[SOCE_BIT];
      end
    end
    // A running context opens at once, or waits for the timer when armed.
    for (int i = 0; i < CTX_COUNT; i++)
    begin
      s_next.startedReg[i] = s_reg.runReg[i] &&
        (s_reg.startedReg[i] || !s_reg.soceReg[i] || cycleHit[i]);
    end
  end

  // ---------------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.matchReg <= {CTX_COUNT{MATCH_RESET}};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  assign prdata = s_reg.prdataReg;
  assign pready = s_reg.preadyReg;
  assign pslverr = s_reg.pslverrReg;
  assign pktAccept = s_reg.acceptReg;
  assign syncHit = s_reg.syncHitReg;
  assign ctxStarted = s_reg.startedReg;

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // A match register read completes with the reserved bits low.
  sequence matchRead;
    psel && penable && !pwrite && !pready && isMatchAddr(paddr);
  endsequence

  resvd_bit27_a: assert property (matchRead |=> pready && !prdata[27])
    else $error("Reserved bit 27 read back as one.");
  resvd_bit7_a: assert property (matchRead |=> pready && !prdata[7])
    else $error("Reserved bit 7 read back as one.");

  generate
    for (g = 0; g < CTX_COUNT; g++)
    begin : gChk
      // A packet on this context's channel while the context is open.
      sequence openPkt;
        pktValid && ctxStarted[g] && pktChannel == s_reg.matchReg[g][CHAN_HI:0];
      endsequence

      tag11_accept_a: assert property (openPkt ##0 (pktTag == 2'h3 &&
        s_reg.matchReg[g][TAG11_BIT]) |=> pktAccept[g])
        else $error("Tag 11 packet not accepted.");
      tag10_accept_a: assert property (openPkt ##0 (pktTag == 2'h2 &&
        s_reg.matchReg[g][TAG10_BIT]) |=> pktAccept[g])
        else $error("Tag 10 packet not accepted.");
      tag00_accept_a: assert property (openPkt ##0 (pktTag == 2'h0 &&
        !s_reg.matchReg[g][TAG00_BIT]) |=> !pktAccept[g])
        else $error("Tag 00 packet accepted while disabled.");
      sync_gate_a: assert property (openPkt ##0 (pktTag == 2'h1 &&
        s_reg.matchReg[g][SYNC_GATE_BIT] && pktSync[3:2] != 2'h0) |=> !pktAccept[g])
        else $error("Gated tag 01 packet accepted.");
      gate_clear_a: assert property (openPkt ##0 (pktTag == 2'h1 &&
        s_reg.matchReg[g][TAG01_BIT] && !s_reg.matchReg[g][SYNC_GATE_BIT])
        |=> pktAccept[g])
        else $error("Ungated tag 01 packet refused.");
      chan_only_a: assert property (pktValid &&
        pktChannel != s_reg.matchReg[g][CHAN_HI:0] |=> !pktAccept[g] && !syncHit[g])
        else $error("Packet on another channel accepted.");
      closed_refuse_a: assert property (!ctxStarted[g] |=> !pktAccept[g])
        else $error("Packet accepted while context closed.");
      sync_wait_a: assert property (openPkt ##0 (waitSelect[2*g+1:2*g] == 2'h3 &&
        pktSync == s_reg.matchReg[g][SYNC_HI:SYNC_LO]) |=> syncHit[g])
        else $error("Sync wait not reported.");
      cycle_start_a: assert property (s_reg.runReg[g] && s_reg.soceReg[g] && !ctxStarted[g]
        |=> ctxStarted[g] == ($past(timerNow) == $past(s_reg.matchReg[g][CYC_HI:CYC_LO])))
        else $error("Start-on-cycle opened at the wrong time.");
    end
  endgenerate

endmodule

// ---- verification/irm_link_model.sv ----
// Stand-in for the link receive path: offers one packet header per request.
module irm_link_model
(
  input wire logic clk_sys,  // System clock.
  input wire logic go,  // Offer a header at the next edge.
  input wire logic [11:0] hdr,  // Channel, tag and sync to offer.
  output logic pktValid = 1'b0,  // One-cycle header strobe.
  output logic [5:0] pktChannel = '0,  // Packet channel.
  output logic [1:0] pktTag = '0,  // Packet tag.
  output logic [3:0] pktSync = '0  // Packet sync.
);
  timeunit 1ns;
  timeprecision 1ns;

  // Outside a strobe the fields flip every cycle, so that a filter which
  // looks at them without the strobe cannot pass by luck.
  always @(posedge clk_sys)
  begin
    pktValid <= go;
    if (go)
      {pktChannel, pktTag, pktSync} <= hdr;
    else
      {pktChannel, pktTag, pktSync} <= ~{pktChannel, pktTag, pktSync};
  end
endmodule

// ---- verification/irm_match_filter_bench.sv ----
module irm_match_filter_bench;
  import irm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Signals and reference model state.
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;  // 100 ns clock.
  logic reset = 1'b1;  // Held for six cycles.
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // APB controls.
  logic [ADDR_W-1:0] paddr = '0;  // APB address.
  logic [DATA_W-1:0] pwdata = '0, prdata;  // APB data.
  logic pready, pslverr;  // APB answer.
  logic go = 1'b0;  // Header request to the link model.
  logic [11:0] hdr = '0;  // Header fields for the link model.
  logic pktValid;
  logic [5:0] pktChannel;
  logic [1:0] pktTag;
  logic [3:0] pktSync;
  logic [6:0] timerSecondsCount = '0;
  logic [12:0] timerCycleIndex = '0;
  logic [7:0] waitSelect = '0;
  logic [3:0] pktAccept, syncHit, ctxStarted;
  int n_errors = 0, checks_done = 0, cycles = 0;
  int seed = 32'h9753;
  logic [31:0] mreg [4];  // Expected match registers.
  logic [3:0] started = '0;  // Expected open contexts.
  logic [31:0] rd;  // Last read data.
  logic err;  // Last error flag.

  irm_link_model LINK (.clk_sys(clk_sys), .go(go), .hdr(hdr), .pktValid(pktValid),
    .pktChannel(pktChannel), .pktTag(pktTag), .pktSync(pktSync));

  irm_match_filter DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pktValid(pktValid), .pktChannel(pktChannel), .pktTag(pktTag),
    .pktSync(pktSync), .timerSecondsCount(timerSecondsCount),
    .timerCycleIndex(timerCycleIndex), .waitSelect(waitSelect), .pktAccept(pktAccept),
    .syncHit(syncHit), .ctxStarted(ctxStarted));

  always #50 clk_sys = ~clk_sys;

  // The whole run needs under a thousand cycles; a hang is cut off here.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkCtx(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] mAddr(input int c);
    return MATCH_BASE + CTX_STRIDE * 16'(c);
  endfunction

  function automatic logic [15:0] cAddr(input int c);
    return CTRL_BASE + CTX_STRIDE * 16'(c);
  endfunction

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No wait-state count is assumed; only the bench timeout ends a hang.
    do
    begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrMatch(input int c, input logic [31:0] w);
    apb(1'b1, mAddr(c), w);
    mreg[c] = w & 32'hf7ffff7f;  // Bits 27 and 7 never store.
  endtask

  // Offers one header and compares both per-context results with the model.
  task automatic sendPkt(input logic [5:0] ch, input logic [1:0] tg, input logic [3:0] sy);
    logic [3:0] ea, es;
    logic [7:0] ws;
    logic [31:0] m;
    ws = 8'($random(seed)) | 8'haa;
    @(posedge clk_sys);
    go <= 1'b1;
    hdr <= {ch, tg, sy};
    waitSelect <= ws;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    for (int c = 0; c < 4; c++)
    begin
      m = mreg[c];
      ea[c] = started[c] && ch == m[5:0] && m[28 + tg]
        && !(tg == 2'b01 && m[6] && sy[3:2] != 2'b00);
      es[c] = started[c] && ch == m[5:0] && ws[2*c+:2] == 2'b11 && sy == m[11:8];
    end
    chkCtx(pktAccept, ea);
    chkCtx(syncHit, es);
  endtask

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] w;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      mreg[c] = 32'h0;
      apb(1'b0, mAddr(c), '0);
      chkReg(rd, 32'h0);
      apb(1'b0, cAddr(c), '0);
      chkReg(rd, 32'h0);
      apb(1'b1, cAddr(c), 32'h00008000);
      started[c] = 1'b1;
    end
    repeat (2) @(posedge clk_sys);
    chkCtx(ctxStarted, started);
    apb(1'b0, 16'h0000, '0);
    chkReg(rd, 32'h0);
    chkCtx({3'b000, err}, 4'h1);
    // Random filters on few channels and sync values, so that hits are frequent.
    for (int i = 0; i < 64; i++)
    begin
      w = $random(seed);
      w[5:0] = 6'($random(seed) & 3);
      w[9:8] = 2'b00;
      wrMatch(i % 4, w);
      apb(1'b0, mAddr(i % 4), '0);
      chkReg(rd, mreg[i % 4]);
      timerSecondsCount <= 7'($random(seed));
      timerCycleIndex <= 13'($random(seed));
      sendPkt(6'($random(seed) & 3), 2'($random(seed)),
        {2'($random(seed)), 2'b00});
    end
    // Context 1 waits for cycle 01:0b3c before it opens.
    apb(1'b1, cAddr(1), 32'h0);
    started[1] = 1'b0;
    repeat (2) @(posedge clk_sys);
    chkCtx(ctxStarted, started);
    timerSecondsCount <= 7'h50;
    timerCycleIndex <= 13'h0b3c;
    wrMatch(1, {4'hf, 1'b0, 15'h2b3c, 12'h002});
    apb(1'b1, cAddr(1), 32'h20008000);
    repeat (3) @(posedge clk_sys);
    chkCtx(ctxStarted, started);
    sendPkt(6'h02, 2'b11, 4'h0);
    @(posedge clk_sys);
    timerSecondsCount <= 7'h51;
    started[1] = 1'b1;
    repeat (3) @(posedge clk_sys);
    chkCtx(ctxStarted, started);
    sendPkt(6'h02, 2'b11, 4'h0);
    // The opened context reads back enable, run and the open flag, with no error.
    apb(1'b0, cAddr(1), '0);
    chkReg(rd, 32'h20008400);
    chkCtx({3'b000, err}, 4'h0);
    stop_test();
  end
endmodule
